// ===== rtl/isc_interrupt_status_collector.sv
// interrupt status collector with avalon-mm register slave
`timescale 1ns/10ps
`default_nettype none

module isc_interrupt_status_collector #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic softReset,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irqOut,
  input wire logic transmitResetDone,
  input wire logic receiveResetDone,
  input wire logic parityErrorFlag,
  input wire logic systemErrorSignalled,
  input wire logic masterAbortReceived,
  input wire logic targetAbortReceived,
  input wire logic receiveStatusFifoOverrun,
  input wire logic phyInterrupt,
  input wire logic networkWakeup,
  input wire logic softwareInterruptRequest,
  input wire logic statisticsThreshold,
  input wire logic transmitFifoUnderrun,
  input wire logic transmitEngineIdle,
  input wire logic transmitFailed,
  input wire logic transmitDescriptorDone,
  input wire logic transmitSucceeded,
  input wire logic receiveFifoOverrun,
  input wire logic receiveEngineIdle,
  input wire logic receiveEarlyThreshold,
  input wire logic receiveFailed,
  input wire logic receiveDescriptorDone,
  input wire logic receiveSucceeded
);

  logic [31:0] status_q;
  logic [31:0] status_d;
  logic [31:0] mask_q;
  logic [31:0] mask_d;
  logic [31:0] readData_q;
  logic [31:0] readData_d;
  logic waitReq_q;
  logic irq_q;
  logic parityPrev_q;
  logic txIdlePrev_q;
  logic rxIdlePrev_q;
  logic [31:0] eventVec;
  logic [31:0] statusView;
  logic [31:0] byteMask;
  logic takeAccess;
  logic hitStatus;
  logic hitMask;
  logic clearRead;
  logic maskWrite;

  localparam logic [ADDR_W-1:0] OFFS_STATUS_W = ADDR_W'(isc_pkg::OFFS_STATUS);
  localparam logic [ADDR_W-1:0] OFFS_MASK_W = ADDR_W'(isc_pkg::OFFS_MASK);

  // the request is taken on its first cycle; waitrequest drops one cycle later
  assign takeAccess = (avs_read || avs_write) && waitReq_q;
  assign hitStatus = (avs_address == OFFS_STATUS_W);
  assign hitMask = (avs_address == OFFS_MASK_W);
  assign clearRead = takeAccess && avs_read && hitStatus;
  assign maskWrite = takeAccess && avs_write && hitMask;

  // gather events into their bit positions
  always_comb begin
    eventVec = 32'h0;
    eventVec[isc_pkg::BIT_TX_RESET_DONE] = transmitResetDone;
    eventVec[isc_pkg::BIT_RX_RESET_DONE] = receiveResetDone;
    eventVec[isc_pkg::BIT_PARITY] = parityErrorFlag && !parityPrev_q;
    eventVec[isc_pkg::BIT_SYS_ERR] = systemErrorSignalled;
    eventVec[isc_pkg::BIT_MASTER_ABORT] = masterAbortReceived;
    eventVec[isc_pkg::BIT_TARGET_ABORT] = targetAbortReceived;
    eventVec[isc_pkg::BIT_RX_STAT_OVR] = receiveStatusFifoOverrun;
    eventVec[isc_pkg::BIT_PHY] = phyInterrupt;
    eventVec[isc_pkg::BIT_WAKE] = networkWakeup;
    eventVec[isc_pkg::BIT_SOFT_IRQ] = softwareInterruptRequest;
    eventVec[isc_pkg::BIT_STATS] = statisticsThreshold;
    eventVec[isc_pkg::BIT_TX_UNDERRUN] = transmitFifoUnderrun;
    eventVec[isc_pkg::BIT_TX_IDLE] = transmitEngineIdle && !txIdlePrev_q;
    eventVec[isc_pkg::BIT_TX_FAIL] = transmitFailed;
    eventVec[isc_pkg::BIT_TX_DESC] = transmitDescriptorDone;
    eventVec[isc_pkg::BIT_TX_OK] = transmitSucceeded;
    eventVec[isc_pkg::BIT_RX_OVR] = receiveFifoOverrun;
    eventVec[isc_pkg::BIT_RX_IDLE] = receiveEngineIdle && !rxIdlePrev_q;
    eventVec[isc_pkg::BIT_RX_EARLY] = receiveEarlyThreshold;
    eventVec[isc_pkg::BIT_RX_FAIL] = receiveFailed;
    eventVec[isc_pkg::BIT_RX_DESC] = receiveDescriptorDone;
    eventVec[isc_pkg::BIT_RX_OK] = receiveSucceeded;
  end

  // edge detectors; idle engines at reset so no spurious idle event
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      parityPrev_q <= 1'b0;
      txIdlePrev_q <= 1'b1;
      rxIdlePrev_q <= 1'b1;
    end else begin
      parityPrev_q <= parityErrorFlag;
      txIdlePrev_q <= transmitEngineIdle;
      rxIdlePrev_q <= receiveEngineIdle;
    end
  end

  // visible status: stored bits plus the derived summary
  always_comb begin
    statusView = status_q & isc_pkg::VALID_BITS;
    statusView[isc_pkg::BIT_SUMMARY] = |status_q[isc_pkg::HIGH_HI:isc_pkg::HIGH_LO];
  end

  // set wins over the read clear so no event is lost
  always_comb begin
    status_d = status_q;
    if (clearRead) begin
      status_d = 32'h0;
    end
    status_d = (status_d | eventVec) & isc_pkg::STORE_BITS;
  end

  // writes never reach status_q; only rst_n or soft reset reloads it
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      status_q <= isc_pkg::STATUS_RESET & isc_pkg::STORE_BITS;
    end else if (softReset) begin
      status_q <= isc_pkg::STATUS_RESET & isc_pkg::STORE_BITS;
    end else begin
      status_q <= status_d;
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      byteMask[i*8 +: 8] = {8{avs_byteenable[i]}};
    end
  end

  always_comb begin
    mask_d = mask_q;
    if (maskWrite) begin
      mask_d = ((mask_q & ~byteMask) | (avs_writedata & byteMask)) & isc_pkg::VALID_BITS;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mask_q <= isc_pkg::MASK_RESET;
    end else if (softReset) begin
      mask_q <= isc_pkg::MASK_RESET;
    end else begin
      mask_q <= mask_d;
    end
  end

  // read data captured on the take edge, together with the clear
  always_comb begin
    readData_d = readData_q;
    if (takeAccess && avs_read) begin
      if (hitStatus) begin
        readData_d = statusView;
      end else if (hitMask) begin
        readData_d = mask_q;
      end else begin
        readData_d = 32'h0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      readData_q <= 32'h0;
    end else begin
      readData_q <= readData_d;
    end
  end

  // one wait cycle per access, fixed
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      waitReq_q <= 1'b1;
    end else begin
      waitReq_q <= !takeAccess;
    end
  end

  // registered to keep the output glitch free; one cycle of latency
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(statusView & mask_q);
    end
  end

  assign avs_readdata = readData_q;
  assign avs_waitrequest = waitReq_q;
  assign irqOut = irq_q;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_take_read_status;
    avs_read && waitReq_q && hitStatus;
  endsequence

  sequence s_answer;
    !waitReq_q ##1 waitReq_q;
  endsequence

  property p_irq_follows;
    |(statusView & mask_q) |=> irqOut;
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("interrupt not raised for enabled pending bit");

  property p_irq_quiet;
    (statusView & mask_q) == 32'h0 |=> !irqOut;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("interrupt raised with no enabled pending bit");

  property p_event_recorded;
    (eventVec != 32'h0) && !softReset
      |=> ((status_q & $past(eventVec)) == $past(eventVec));
  endproperty
  a_event_recorded: assert property (p_event_recorded)
    else $error("event lost");

  property p_read_returns;
    s_take_read_status |=> (avs_readdata == $past(statusView)) and s_answer;
  endproperty
  a_read_returns: assert property (p_read_returns)
    else $error("status read data or handshake wrong");

  property p_read_clears;
    s_take_read_status and !softReset |=> (status_q == $past(eventVec));
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("status not cleared by read");

  property p_write_ignored;
    avs_write && hitStatus && (eventVec == 32'h0) && !softReset |=> $stable(status_q);
  endproperty
  a_write_ignored: assert property (p_write_ignored)
    else $error("status changed by a write");

  property p_soft_reset;
    softReset |=> (statusView == isc_pkg::STATUS_RESET) && (mask_q == 32'h0);
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset value wrong");

  property p_reserved_zero;
    (avs_readdata & ~isc_pkg::VALID_BITS) == 32'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits read nonzero");

  property p_summary;
    statusView[15] == |statusView[25:16];
  endproperty
  a_summary: assert property (p_summary)
    else $error("summary bit mismatch");

  property p_parity_edge;
    parityErrorFlag && !parityPrev_q && !softReset |=> status_q[23];
  endproperty
  a_parity_edge: assert property (p_parity_edge)
    else $error("parity error not recorded");

  property p_tx_idle;
    transmitEngineIdle && !txIdlePrev_q && !softReset |=> status_q[isc_pkg::BIT_TX_IDLE];
  endproperty
  a_tx_idle: assert property (p_tx_idle)
    else $error("transmit idle not recorded");

  property p_tx_reset_done;
    transmitResetDone && !softReset |=> status_q[isc_pkg::BIT_TX_RESET_DONE];
  endproperty
  a_tx_reset_done: assert property (p_tx_reset_done)
    else $error("transmit reset done not recorded");

  property p_rx_reset_done;
    receiveResetDone && !softReset |=> status_q[isc_pkg::BIT_RX_RESET_DONE];
  endproperty
  a_rx_reset_done: assert property (p_rx_reset_done)
    else $error("receive reset done not recorded");

  property p_sys_err;
    systemErrorSignalled && !softReset |=> status_q[isc_pkg::BIT_SYS_ERR];
  endproperty
  a_sys_err: assert property (p_sys_err)
    else $error("system error not recorded");

  property p_master_abort;
    masterAbortReceived && !softReset |=> status_q[isc_pkg::BIT_MASTER_ABORT];
  endproperty
  a_master_abort: assert property (p_master_abort)
    else $error("master abort not recorded");

  property p_target_abort;
    targetAbortReceived && !softReset |=> status_q[isc_pkg::BIT_TARGET_ABORT];
  endproperty
  a_target_abort: assert property (p_target_abort)
    else $error("target abort not recorded");

  property p_rx_stat_ovr;
    receiveStatusFifoOverrun && !softReset |=> status_q[isc_pkg::BIT_RX_STAT_OVR];
  endproperty
  a_rx_stat_ovr: assert property (p_rx_stat_ovr)
    else $error("receive status overrun not recorded");

  property p_phy;
    phyInterrupt && !softReset |=> status_q[isc_pkg::BIT_PHY];
  endproperty
  a_phy: assert property (p_phy)
    else $error("phy interrupt not recorded");

  property p_wake;
    networkWakeup && !softReset |=> status_q[isc_pkg::BIT_WAKE];
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake event not recorded");

  property p_soft_irq;
    softwareInterruptRequest && !softReset |=> status_q[isc_pkg::BIT_SOFT_IRQ];
  endproperty
  a_soft_irq: assert property (p_soft_irq)
    else $error("software interrupt not recorded");

  property p_stats;
    statisticsThreshold && !softReset |=> status_q[isc_pkg::BIT_STATS];
  endproperty
  a_stats: assert property (p_stats)
    else $error("statistics threshold not recorded");

  // reserved mask bits would otherwise read back nonzero through avs_readdata
  property p_mask_reserved;
    (mask_q & ~isc_pkg::VALID_BITS) == 32'h0;
  endproperty
  a_mask_reserved: assert property (p_mask_reserved)
    else $error("reserved mask bits nonzero");

endmodule

`default_nettype wire

// ===== rtl/isc_pkg.sv
// constants and field layout of the interrupt status collector
// What this block does
// - interrupt out when any enabled status bit set
// - status bits record events regardless of mask
// - status read returns bits then clears all except events arriving on the same edge
// - writes to status register are ignored
// - status at 0x10, resets to 0x03008000
// - bit 25 on transmit reset done
// - bit 24 on receive reset done
// - bit 23 when parity error flag sets
// - bit 22 on system error signalled
// - bit 21 on master abort received
// - bit 20 on target abort received
// - bit 16 on receive status fifo overrun
// - bit 15 is OR of bits 25..16
// - bit 14 on phy interrupt
// - bit 13 on network wakeup
// - bit 12 on software interrupt request
// - bit 11 on statistics threshold reached
// - bit 10 on transmit fifo underrun
// - bit 9 when transmit engine goes idle
// - bit 8 on failed transmit write-back
// - mask clears on reset; 1 enables bit
// - bit 6 on successful transmit write-back
// - bit 5 on receive fifo overrun
// - bit 0 on good receive write-back
package isc_pkg;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0] OFFS_STATUS = 8'h10;
  localparam logic [7:0] OFFS_MASK = 8'h14;
  localparam logic [31:0] STATUS_RESET = 32'h03008000;
  localparam logic [31:0] MASK_RESET = 32'h00000000;
  // bits that exist at all; everything else reads zero
  localparam logic [31:0] VALID_BITS = 32'h03f1ffff;
  localparam int unsigned BIT_TX_RESET_DONE = 25;
  localparam int unsigned BIT_RX_RESET_DONE = 24;
  localparam int unsigned BIT_PARITY = 23;
  localparam int unsigned BIT_SYS_ERR = 22;
  localparam int unsigned BIT_MASTER_ABORT = 21;
  localparam int unsigned BIT_TARGET_ABORT = 20;
  localparam int unsigned BIT_RX_STAT_OVR = 16;
  localparam int unsigned BIT_SUMMARY = 15;
  localparam int unsigned BIT_PHY = 14;
  localparam int unsigned BIT_WAKE = 13;
  localparam int unsigned BIT_SOFT_IRQ = 12;
  localparam int unsigned BIT_STATS = 11;
  localparam int unsigned BIT_TX_UNDERRUN = 10;
  localparam int unsigned BIT_TX_IDLE = 9;
  localparam int unsigned BIT_TX_FAIL = 8;
  localparam int unsigned BIT_TX_DESC = 7;
  localparam int unsigned BIT_TX_OK = 6;
  localparam int unsigned BIT_RX_OVR = 5;
  localparam int unsigned BIT_RX_IDLE = 4;
  localparam int unsigned BIT_RX_EARLY = 3;
  localparam int unsigned BIT_RX_FAIL = 2;
  localparam int unsigned BIT_RX_DESC = 1;
  localparam int unsigned BIT_RX_OK = 0;
  localparam int unsigned HIGH_LO = 16;
  localparam int unsigned HIGH_HI = 25;
  localparam logic [31:0] HIGH_BITS = 32'h03ff0000;
  // summary bit is derived, never stored
  localparam logic [31:0] STORE_BITS = 32'h03f17fff;
endpackage

// ===== verif/isc_host_model.sv
// avalon-mm host model that reads and writes the collector registers
`timescale 1ns/10ps
`default_nettype none

module isc_host_model (
  input wire logic sys_clk,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  output logic [7:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable
);
  initial begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
  end

  // request held until waitrequest is seen low at a rising edge
  task automatic access(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
      input logic [3:0] be, output logic [31:0] rdata);
    avs_address <= addr;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= wdata;
    avs_byteenable <= be;
    @(posedge sys_clk);
    while (avs_waitrequest) @(posedge sys_clk);
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // released data inverted so stale values never look valid
    avs_writedata <= ~wdata;
    // idle edge so a following call never re-drives in the same step
    @(posedge sys_clk);
  endtask
endmodule

`default_nettype wire

// ===== verif/isc_interrupt_status_collector_tb.sv
// self-checking bench for the interrupt status collector
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin samplesChecked++; if ((got) !== (exp)) begin numErrors++; \
  $display("[FAIL] %0t got %h exp %h", $time, (got), (exp)); end end

module isc_interrupt_status_collector_tb;
  typedef struct {
    logic [31:0] mask;
    logic [31:0] expSt;
    logic expIrq;
  } isc_row_t;
  // idle inputs rest high, all others rest low
  localparam logic [25:0] RESTV = 26'h0000210;
  localparam int BITS[22] = '{25, 24, 23, 22, 21, 20, 16, 14, 13, 12, 11, 10, 9, 8, 7, 6, 5, 4,
    3, 2, 1, 0};
  logic sysClk;
  logic rstN;
  logic softReset;
  logic [25:0] evt;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irqOut;
  logic [31:0] rd;
  isc_row_t rows[22];
  int numErrors = 0;
  int samplesChecked = 0;
  int cyc = 0;

  isc_host_model host_u (.sys_clk(sysClk), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable));

  isc_interrupt_status_collector #(.ADDR_W(8)) dut_u (.sys_clk(sysClk), .rst_n(rstN),
    .softReset(softReset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irqOut(irqOut),
    .transmitResetDone(evt[25]), .receiveResetDone(evt[24]), .parityErrorFlag(evt[23]),
    .systemErrorSignalled(evt[22]), .masterAbortReceived(evt[21]),
    .targetAbortReceived(evt[20]), .receiveStatusFifoOverrun(evt[16]),
    .phyInterrupt(evt[14]), .networkWakeup(evt[13]), .softwareInterruptRequest(evt[12]),
    .statisticsThreshold(evt[11]), .transmitFifoUnderrun(evt[10]),
    .transmitEngineIdle(evt[9]), .transmitFailed(evt[8]), .transmitDescriptorDone(evt[7]),
    .transmitSucceeded(evt[6]), .receiveFifoOverrun(evt[5]), .receiveEngineIdle(evt[4]),
    .receiveEarlyThreshold(evt[3]), .receiveFailed(evt[2]), .receiveDescriptorDone(evt[1]),
    .receiveSucceeded(evt[0]));

  always #50 sysClk = ~sysClk;

  task automatic closeOut();
    $display("checks %0d mismatches %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // hang guard, far beyond the few hundred cycles the tests need
  always @(posedge sysClk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      $display("[FAIL] %0t timeout", $time);
      numErrors++;
      closeOut();
    end
  end

  task automatic rdReg(input logic [7:0] a, output logic [31:0] d);
    host_u.access(1'b0, a, 32'h0, 4'hf, d);
  endtask

  task automatic wrReg(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] junk;
    host_u.access(1'b1, a, d, be, junk);
  endtask

  // away from rest and back: a pulse, or a rising edge for level inputs
  task automatic fire(input int b);
    evt[b] <= ~RESTV[b];
    @(posedge sysClk);
    evt[b] <= RESTV[b];
    @(posedge sysClk);
  endtask

  initial begin
    sysClk = 1'b0;
    rstN = 1'b0;
    softReset = 1'b0;
    evt = RESTV;
    repeat (3) @(posedge sysClk);
    rstN <= 1'b1;
    @(posedge sysClk);
    rdReg(8'h14, rd);
    `CHK(rd, 32'h0)
    `CHK(irqOut, 1'b0)
    rdReg(8'h10, rd);
    `CHK(rd, 32'h03008000)
    rdReg(8'h10, rd);
    `CHK(rd, 32'h0)
    $display("test reset done");
    // even rows enable only the event bit, odd rows everything else
    for (int i = 0; i < 22; i++) begin
      rows[i].mask = i[0] ? ~(32'h1 << BITS[i]) : (32'h1 << BITS[i]);
      rows[i].expSt = (32'h1 << BITS[i]) | ((BITS[i] >= 16) ? 32'h00008000 : 32'h0);
      rows[i].expIrq = |(rows[i].expSt & rows[i].mask);
    end
    for (int i = 0; i < 22; i++) begin
      wrReg(8'h14, rows[i].mask, 4'hf);
      fire(BITS[i]);
      repeat (2) @(posedge sysClk);
      `CHK(irqOut, rows[i].expIrq)
      rdReg(8'h10, rd);
      `CHK(rd[31:11], rows[i].expSt[31:11])
      `CHK(rd[10:0], rows[i].expSt[10:0])
      rdReg(8'h10, rd);
      `CHK(rd, 32'h0)
      `CHK(irqOut, 1'b0)
    end
    $display("test table done");
    fire(12);
    wrReg(8'h10, 32'h0, 4'hf);
    wrReg(8'h10, 32'hffffffff, 4'hf);
    rdReg(8'h10, rd);
    `CHK(rd, 32'h00001000)
    wrReg(8'h14, 32'hffffffff, 4'hf);
    wrReg(8'h20, 32'h0, 4'hf);
    rdReg(8'h14, rd);
    `CHK(rd, 32'h03f1ffff)
    rdReg(8'h20, rd);
    `CHK(rd, 32'h0)
    wrReg(8'h14, 32'h0, 4'h1);
    rdReg(8'h14, rd);
    `CHK(rd, 32'h03f1ff00)
    evt <= ~RESTV;
    @(posedge sysClk);
    evt <= RESTV;
    repeat (2) @(posedge sysClk);
    `CHK(irqOut, 1'b1)
    rdReg(8'h10, rd);
    `CHK(rd, 32'h03f1ffff)
    $display("test write and reserved done");
    // event lands on the very edge that takes the clearing read
    fork
      rdReg(8'h10, rd);
      fire(10);
    join
    `CHK(rd, 32'h0)
    rdReg(8'h10, rd);
    `CHK(rd, 32'h00000400)
    $display("test clear race done");
    wrReg(8'h14, 32'h00001000, 4'hf);
    fire(12);
    softReset <= 1'b1;
    @(posedge sysClk);
    softReset <= 1'b0;
    repeat (2) @(posedge sysClk);
    `CHK(irqOut, 1'b0)
    rdReg(8'h14, rd);
    `CHK(rd, 32'h0)
    rdReg(8'h10, rd);
    `CHK(rd, 32'h03008000)
    $display("test soft reset done");
    closeOut();
  end
endmodule

`default_nettype wire
